// ---- rtl/sps_defs.vh ----
// constants for the servo parameter and pulse scaling block
`ifndef SPS_DEFS_VH
`define SPS_DEFS_VH
`define SPS_ADDR_CTRL 4'h0
`define SPS_ADDR_REGEN 4'h1
`define SPS_ADDR_ABS 4'h2
`define SPS_ADDR_PINF 4'h3
`define SPS_ADDR_PPR 4'h4
`define SPS_ADDR_NUM 4'h5
`define SPS_ADDR_DEN 4'h6
`define SPS_ADDR_APPLY 4'h7
`define SPS_ADDR_STAT 4'h8
`define SPS_ADDR_MASK 4'h9
`define SPS_ADDR_POS 4'ha
`define SPS_ADDR_ACT 4'hb
`define SPS_PPR_MIN 32'd1000
`define SPS_PPR_MAX 32'd50000
`define SPS_GEAR_MAX 32'd1048576
`define SPS_GEAR_RST 32'd1
`define SPS_REGEN_LO 8'h80
`define SPS_REGEN_HI 8'h85
`define SPS_REGEN_FAN 8'hfa
`define SPS_REGEN_NONE 8'h00
`define SPS_TORQ_STD 16'd300
`define SPS_TORQ_EXT 16'd350
`define SPS_ABS_INC 2'h0
`define SPS_ABS_DI 2'h1
`define SPS_ABS_COMM 2'h2
`define SPS_ST_PARAM 0
`define SPS_ST_OVHT 1
`define SPS_ST_OVL1 2
`define SPS_ST_OVL2 3
`define SPS_APPLY_KEY 32'h0000a5a5
`endif

// ---- rtl/sps_scaler.v ----
// gear scaler with remainder carry for command pulses
`timescale 1ns/1ps
`default_nettype none
module sps_scaler #(
  parameter W = 21,
  parameter PW = 32
) (
  input wire clk, // clock
  input wire arst_n, // async reset, active low
  input wire clear, // zero position and remainder
  input wire pulse, // one command pulse
  input wire dir, // 1 reverse
  input wire [W-1:0] num, // gear numerator
  input wire [W-1:0] den, // gear denominator
  output reg [PW-1:0] pos_reg // scaled position
);
  reg [W:0] rem_reg;
  reg [W:0] remNext;
  reg [PW-1:0] posNext;
  reg [W:0] step;
  reg [W:0] acc;
  reg [W:0] quot;
  // forward: add num to remainder, move whole units out
  // reverse: borrow against den-1-rem so the fraction stays exact
  always @*
  begin
    remNext = rem_reg;
    posNext = pos_reg;
    step = {1'b0, num};
    acc = rem_reg;
    quot = {(W+1){1'b0}};
    if (pulse)
    begin
      if (dir)
        acc = step + ({1'b0, den} - rem_reg - {{W{1'b0}}, 1'b1});
      else
        acc = rem_reg + step;
      quot = acc / {1'b0, den};
      if (dir)
      begin
        remNext = {1'b0, den} - {{W{1'b0}}, 1'b1} - acc % {1'b0, den};
        posNext = pos_reg - {{(PW-W-1){1'b0}}, quot};
      end
      else
      begin
        remNext = acc % {1'b0, den};
        posNext = pos_reg + {{(PW-W-1){1'b0}}, quot};
      end
    end
  end
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rem_reg <= {(W+1){1'b0}};
      pos_reg <= {PW{1'b0}};
    end
    else if (clear)
    begin
      rem_reg <= {(W+1){1'b0}};
      pos_reg <= {PW{1'b0}};
    end
    else
    begin
      rem_reg <= remNext;
      pos_reg <= posNext;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sps_servo_param.v ----
// parameter latching, validation and command pulse scaling top
// Function
// - written settings take effect only after power cycle (apply strobe)
// - pulses-per-rev zero selects gear numerator/denominator scaling
// - pulses-per-rev 1000..50000 means that many pulses per turn
// - numerator range 1..1048576, reset 1, position mode only
// - denominator range 1..1048576, reset 1, scales by num/den
// - motor moves pulse count times num over den
// - detect field: 0 incremental, 1 absolute via inputs, 2 via comms
// - absolute detection only applies in position control
// - pin function 0 output assign device, 1 brake interlock
// - unsupported regen code raises parameter error
// - extended torque with unsupported motor raises parameter error
// - extended torque raises peak limit 300 to 350 percent
// - overload beyond characteristic raises overheat, overload1, overload2
// - regen codes 80..85 and fa are options
// - large drive units need fixed regen value
// - control mode offers high response loop
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sps_defs.vh"
module sps_servo_param #(
  parameter GW = 21,
  parameter PW = 32,
  parameter ENC_RES = 262144
) (
  input wire clk, // 100 MHz clock
  input wire arst_n, // async reset, active low
  input wire [3:0] addr, // register address
  input wire [31:0] wdata, // write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [31:0] rdata_reg, // read data, cycle after rd
  input wire cmdPulse, // one-cycle command pulse
  input wire cmdDir, // command direction
  input wire servoOn, // servo on
  input wire motorExtOk, // attached motor supports extended torque
  input wire largeUnit, // drive unit of large rating
  input wire fanAllowed, // amplifier allows fan resistor code
  input wire overheatEv, // motor thermal limit exceeded
  input wire overload1Ev, // overload characteristic 1 exceeded
  input wire overload2Ev, // overload characteristic 2 exceeded
  input wire outputAssignDev, // device from output assign setting
  input wire brakeInterlock, // brake interlock signal
  output reg pinOut_reg, // selected output pin level
  output wire highResp, // high response loop active
  output wire [15:0] torqueLimit, // peak torque percent
  output wire absActive, // absolute detection active
  output wire [1:0] absMode, // active detection mode
  output wire paramError, // parameter error alarm
  output wire irq // interrupt, level
);
  // shadow (written) settings
  reg [7:0] ctrlW_reg;
  reg [7:0] regenW_reg;
  reg [1:0] absW_reg;
  reg pinW_reg;
  reg [15:0] pprW_reg;
  reg [GW-1:0] numW_reg;
  reg [GW-1:0] denW_reg;
  // active settings, loaded at reset/power cycle only
  reg [7:0] ctrlA_reg;
  reg [7:0] regenA_reg;
  reg [1:0] absA_reg;
  reg pinA_reg;
  reg [15:0] pprA_reg;
  reg [GW-1:0] numA_reg;
  reg [GW-1:0] denA_reg;
  reg [3:0] stat_reg;
  reg [3:0] statNext;
  reg [3:0] mask_reg;
  reg [31:0] rdNext;
  wire [PW-1:0] posCount;
  wire posMode;
  wire extTorque;
  wire regenBad;
  wire torqueBad;
  wire applyHit;
  wire [GW-1:0] sclNum;
  wire [GW-1:0] sclDen;
  // next values and registered copies of the data outputs
  wire highResp_next;
  wire [15:0] torque_next;
  wire absCodeOk;
  wire [1:0] absMode_next;
  wire absActive_next;
  wire paramErr_next;
  reg highResp_reg;
  reg [15:0] torque_reg;
  reg absActive_reg;
  reg [1:0] absMode_reg;
  reg paramErr_reg;

  // gear constants cut to the gear width on purpose
  localparam [31:0] GEAR_RST_W = `SPS_GEAR_RST;
  localparam [31:0] GEAR_MAX_W = `SPS_GEAR_MAX;
  localparam [31:0] ENC_RES_W = ENC_RES;
  localparam [GW-1:0] GEAR_ONE = GEAR_RST_W[GW-1:0];
  localparam [GW-1:0] GEAR_TOP = GEAR_MAX_W[GW-1:0];
  localparam [GW-1:0] ENC_NUM = ENC_RES_W[GW-1:0];

  function [GW-1:0] clampGear;
    input [31:0] v;
    begin
      if (v == 32'd0)
        clampGear = GEAR_ONE;
      else if (v > `SPS_GEAR_MAX)
        clampGear = GEAR_TOP;
      else
        clampGear = v[GW-1:0];
    end
  endfunction

  // gear words read back zero-extended to the bus width
  function [31:0] zextGear;
    input [GW-1:0] g;
    begin
      zextGear = {{(32-GW){1'b0}}, g};
    end
  endfunction

  // ppr takes zero or the turn range; anything else is refused
  function pprAccept;
    input [31:0] v;
    begin
      pprAccept = (v == 32'd0) ||
        (v >= `SPS_PPR_MIN && v <= `SPS_PPR_MAX);
    end
  endfunction

  function regenValid;
    input [7:0] c;
    input big;
    input fan;
    begin
      if (big)
        regenValid = (c == `SPS_REGEN_NONE);
      else if (c == `SPS_REGEN_NONE)
        regenValid = 1'b1;
      else if (c >= `SPS_REGEN_LO && c <= `SPS_REGEN_HI)
        regenValid = 1'b1;
      else if (c == `SPS_REGEN_FAN)
        regenValid = fan;
      else
        regenValid = 1'b0;
    end
  endfunction

  // ctrl bits: [1:0] mode 0 position, [4] high response, [7] ext torque
  assign posMode = (ctrlA_reg[1:0] == 2'h0);
  assign highResp_next = ctrlA_reg[4];
  assign extTorque = ctrlA_reg[7];
  assign torque_next = (extTorque && motorExtOk) ? `SPS_TORQ_EXT
    : `SPS_TORQ_STD;
  // code 3 names no detection mode, so it stays incremental
  assign absCodeOk = (absA_reg != 2'h3);
  assign absMode_next = (posMode && absCodeOk) ? absA_reg
    : `SPS_ABS_INC;
  assign absActive_next = (absMode_next != `SPS_ABS_INC);
  assign regenBad = !regenValid(regenA_reg, largeUnit, fanAllowed);
  assign torqueBad = extTorque && !motorExtOk;
  assign paramErr_next = regenBad || torqueBad || !absCodeOk;
  assign irq = |(stat_reg & mask_reg);
  assign highResp = highResp_reg;
  assign torqueLimit = torque_reg;
  assign absActive = absActive_reg;
  assign absMode = absMode_reg;
  assign paramError = paramErr_reg;
  assign applyHit = wr && (addr == `SPS_ADDR_APPLY) &&
    (wdata == `SPS_APPLY_KEY);

  // ppr mode: num = encoder res, den = ppr; else gear
  assign sclNum = (pprA_reg == 16'h0000) ? numA_reg : ENC_NUM;
  assign sclDen = (pprA_reg == 16'h0000) ? denA_reg
    : {{(GW-16){1'b0}}, pprA_reg};

  sps_scaler #(
    .W(GW),
    .PW(PW)
  ) u_scaler (
    .clk(clk),
    .arst_n(arst_n),
    .clear(applyHit),
    .pulse(cmdPulse && posMode && servoOn),
    .dir(cmdDir),
    .num(sclNum),
    .den(sclDen),
    .pos_reg(posCount)
  );

  // software writes land in shadow registers, except the mask, which is written directly
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrlW_reg <= 8'h00;
      regenW_reg <= 8'h00;
      absW_reg <= 2'h0;
      pinW_reg <= 1'b0;
      pprW_reg <= 16'h0000;
      numW_reg <= GEAR_ONE;
      denW_reg <= GEAR_ONE;
      mask_reg <= 4'h0;
    end
    else if (wr)
    begin
      if (addr == `SPS_ADDR_CTRL)
        ctrlW_reg <= wdata[7:0];
      else if (addr == `SPS_ADDR_REGEN)
        regenW_reg <= wdata[7:0];
      else if (addr == `SPS_ADDR_ABS)
        absW_reg <= wdata[1:0];
      else if (addr == `SPS_ADDR_PINF)
        pinW_reg <= wdata[0];
      else if (addr == `SPS_ADDR_PPR)
      begin
        // out of range non-zero values are refused
        if (pprAccept(wdata))
          pprW_reg <= wdata[15:0];
      end
      else if (addr == `SPS_ADDR_NUM)
        numW_reg <= clampGear(wdata);
      else if (addr == `SPS_ADDR_DEN)
        denW_reg <= clampGear(wdata);
      else if (addr == `SPS_ADDR_MASK)
        mask_reg <= wdata[3:0];
    end
  end

  // active copy: reset values, then only on apply (power cycle)
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrlA_reg <= 8'h00;
      regenA_reg <= 8'h00;
      absA_reg <= 2'h0;
      pinA_reg <= 1'b0;
      pprA_reg <= 16'h0000;
      numA_reg <= GEAR_ONE;
      denA_reg <= GEAR_ONE;
    end
    else if (applyHit)
    begin
      ctrlA_reg <= ctrlW_reg;
      regenA_reg <= regenW_reg;
      absA_reg <= absW_reg;
      pinA_reg <= pinW_reg;
      pprA_reg <= pprW_reg;
      numA_reg <= numW_reg;
      denA_reg <= denW_reg;
    end
  end

  // data outputs leave from flip-flops, one cycle behind their sources
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      highResp_reg <= 1'b0;
      torque_reg <= `SPS_TORQ_STD;
      absActive_reg <= 1'b0;
      absMode_reg <= `SPS_ABS_INC;
      paramErr_reg <= 1'b0;
    end
    else
    begin
      highResp_reg <= highResp_next;
      torque_reg <= torque_next;
      absActive_reg <= absActive_next;
      absMode_reg <= absMode_next;
      paramErr_reg <= paramErr_next;
    end
  end

  // pin routing
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pinOut_reg <= 1'b0;
    else if (pinA_reg)
      pinOut_reg <= brakeInterlock;
    else
      pinOut_reg <= outputAssignDev;
  end

  // sticky status, set beats read clear
  always @*
  begin
    statNext = stat_reg;
    if (rd && addr == `SPS_ADDR_STAT)
      statNext = 4'h0;
    if (paramError)
      statNext[`SPS_ST_PARAM] = 1'b1;
    if (overheatEv)
      statNext[`SPS_ST_OVHT] = 1'b1;
    if (overload1Ev)
      statNext[`SPS_ST_OVL1] = 1'b1;
    if (overload2Ev)
      statNext[`SPS_ST_OVL2] = 1'b1;
  end

  always @*
  begin
    rdNext = 32'h00000000;
    if (addr == `SPS_ADDR_CTRL)
      rdNext = {24'h000000, ctrlW_reg};
    else if (addr == `SPS_ADDR_REGEN)
      rdNext = {24'h000000, regenW_reg};
    else if (addr == `SPS_ADDR_ABS)
      rdNext = {30'h00000000, absW_reg};
    else if (addr == `SPS_ADDR_PINF)
      rdNext = {31'h00000000, pinW_reg};
    else if (addr == `SPS_ADDR_PPR)
      rdNext = {16'h0000, pprW_reg};
    else if (addr == `SPS_ADDR_NUM)
      rdNext = zextGear(numW_reg);
    else if (addr == `SPS_ADDR_DEN)
      rdNext = zextGear(denW_reg);
    else if (addr == `SPS_ADDR_STAT)
      rdNext = {28'h0000000, stat_reg};
    else if (addr == `SPS_ADDR_MASK)
      rdNext = {28'h0000000, mask_reg};
    else if (addr == `SPS_ADDR_POS)
      rdNext = posCount[31:0];
    else if (addr == `SPS_ADDR_ACT)
      rdNext = {highResp, extTorque, absActive, paramError, 2'h0, absMode,
        pinA_reg, 7'h00, torqueLimit};
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stat_reg <= 4'h0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      stat_reg <= statNext;
      if (rd)
        rdata_reg <= rdNext;
      else
        rdata_reg <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/sps_servo_param_sva.sv ----
// port checker for the servo parameter block
`timescale 1ns/1ps
`default_nettype none
module sps_servo_param_sva (
  input wire logic clk, // clock
  input wire logic arst_n, // async reset
  input wire logic [3:0] addr, // address
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata_reg, // read data
  input wire logic motorExtOk, // motor support
  input wire logic outputAssignDev, // pin source
  input wire logic brakeInterlock, // pin source
  input wire logic pinOut_reg, // pin level
  input wire logic highResp, // loop mode
  input wire logic [15:0] torqueLimit, // peak torque
  input wire logic absActive, // abs active
  input wire logic [1:0] absMode, // abs mode
  input wire logic paramError // alarm
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  chk_torque_pair: assert property (
    torqueLimit == 16'd300 || torqueLimit == 16'd350)
    else $error("torque limit off its two values");
  chk_torque_motor: assert property (
    !motorExtOk |=> torqueLimit == 16'd300)
    else $error("raised torque on unsupported motor");
  chk_ext_error: assert property (
    torqueLimit == 16'd350 && !motorExtOk && !$past(wr) |=> paramError)
    else $error("extended torque without alarm");
  chk_mode_code: assert property (
    absMode != 2'h3) else $error("detection code 3 active");
  chk_abs_gate: assert property (
    absActive |-> absMode != 2'h0) else $error("abs active in incremental");
  chk_abs_inc: assert property (
    absMode == 2'h0 |-> !absActive) else $error("incremental marked abs");
  chk_apply_only: assert property (
    !($past(wr, 2) && $past(addr, 2) == 4'h7) |->
    $stable(highResp) && $stable(absMode))
    else $error("setting took effect without apply");
  chk_pin_follow: assert property (
    $past(outputAssignDev) == $past(brakeInterlock) |->
    pinOut_reg == $past(brakeInterlock))
    else $error("pin not following its source");
  chk_read_blank: assert property (
    !rd |=> rdata_reg == 32'h0) else $error("read data outside window");
endmodule
bind sps_servo_param sps_servo_param_sva chk_u (.clk(clk), .arst_n(arst_n),
  .addr(addr), .wr(wr), .rd(rd), .rdata_reg(rdata_reg),
  .motorExtOk(motorExtOk), .outputAssignDev(outputAssignDev),
  .brakeInterlock(brakeInterlock), .pinOut_reg(pinOut_reg),
  .highResp(highResp), .torqueLimit(torqueLimit), .absActive(absActive),
  .absMode(absMode), .paramError(paramError));
`default_nettype wire

// ---- testbench/sps_host_model.sv ----
// host controller model issuing command pulse bursts
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
  input wire logic clk, // clock
  input wire logic go, // start burst
  input wire logic [7:0] count, // pulses in burst
  input wire logic dir, // direction
  output logic cmdPulse, // command pulse
  output logic cmdDir, // direction
  output logic busy // burst running
);
  logic [8:0] left;
  initial
  begin
    cmdPulse = 1'b0;
    cmdDir = 1'b0;
    busy = 1'b0;
    left = 9'h0;
  end
  // one pulse every second cycle, direction held for the burst
  always @(posedge clk)
  begin
    if (go && !busy)
    begin
      left <= {count, 1'b0};
      busy <= 1'b1;
      cmdDir <= dir;
    end
    else if (busy)
    begin
      cmdPulse <= !left[0] && left != 9'h0;
      left <= left - 9'h1;
      busy <= left != 9'h0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the servo parameter block
`timescale 1ns/1ps
`default_nettype none
`include "sps_defs.vh"
module testbench;
  localparam int ENC = 262144;
  logic clk, arst_n, wr, rd, servoOn, motorExtOk, largeUnit, fanAllowed;
  logic overheatEv, overload1Ev, overload2Ev, outputAssignDev, brakeInterlock;
  logic cmdPulse, cmdDir, pinOut_reg, highResp, absActive, paramError, irq;
  logic go, dir, busy;
  logic [3:0] addr;
  logic [31:0] wdata, rdata_reg, d;
  logic [7:0] count;
  logic [15:0] torqueLimit;
  logic [1:0] absMode;
  int mismatches = 0;
  int samples_checked = 0;
  sps_servo_param #(.ENC_RES(ENC)) dut_u (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_reg(rdata_reg),
    .cmdPulse(cmdPulse), .cmdDir(cmdDir), .servoOn(servoOn),
    .motorExtOk(motorExtOk), .largeUnit(largeUnit), .fanAllowed(fanAllowed),
    .overheatEv(overheatEv), .overload1Ev(overload1Ev),
    .overload2Ev(overload2Ev), .outputAssignDev(outputAssignDev),
    .brakeInterlock(brakeInterlock), .pinOut_reg(pinOut_reg),
    .highResp(highResp), .torqueLimit(torqueLimit), .absActive(absActive),
    .absMode(absMode), .paramError(paramError), .irq(irq));
  sps_host_model host_u (.clk(clk), .go(go), .count(count), .dir(dir),
    .cmdPulse(cmdPulse), .cmdDir(cmdDir), .busy(busy));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata_reg;
  endtask
  task automatic apply(input logic [3:0] a, input logic [31:0] v);
    wrReg(a, v);
    wrReg(`SPS_ADDR_APPLY, `SPS_APPLY_KEY);
    @(posedge clk);
    #1;
  endtask
  task automatic burst(input logic [7:0] n, input logic [31:0] expPos);
    int k;
    @(posedge clk);
    count <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1 k = 0;
    while (busy && k < 600)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 600)
    begin
      mismatches++;
      tally_and_finish;
    end
    repeat (3) @(posedge clk);
    rdReg(`SPS_ADDR_POS, d);
    chk("position", d, expPos);
  endtask
  task automatic tReset;
    rdReg(`SPS_ADDR_NUM, d);
    chk("num reset", d, 32'h1);
    rdReg(`SPS_ADDR_DEN, d);
    chk("den reset", d, 32'h1);
    rdReg(`SPS_ADDR_PPR, d);
    chk("ppr reset", d, 32'h0);
    rdReg(4'hf, d);
    chk("unmapped", d, 32'h0);
    chk("torque reset", torqueLimit, 32'd300);
    $display("test reset done");
  endtask
  task automatic tGear;
    wrReg(`SPS_ADDR_NUM, 32'h0);
    rdReg(`SPS_ADDR_NUM, d);
    chk("num clamp", d, 32'h1);
    wrReg(`SPS_ADDR_DEN, 32'h200000);
    rdReg(`SPS_ADDR_DEN, d);
    chk("den clamp", d, `SPS_GEAR_MAX);
    wrReg(`SPS_ADDR_NUM, 32'h3);
    apply(`SPS_ADDR_DEN, 32'h4);
    @(posedge clk);
    servoOn <= 1'b1;
    burst(8'd7, 32'd5);
    wrReg(`SPS_ADDR_PPR, 32'd999);
    rdReg(`SPS_ADDR_PPR, d);
    chk("ppr refused", d, 32'h0);
    servoOn <= 1'b0;
    apply(`SPS_ADDR_PPR, `SPS_PPR_MIN);
    servoOn <= 1'b1;
    burst(8'd4, 4 * ENC / 1000);
    dir <= 1'b1;
    burst(8'd4, 32'd0);
    dir <= 1'b0;
    servoOn <= 1'b0;
    $display("test gear done");
  endtask
  task automatic tApply;
    @(posedge clk);
    motorExtOk <= 1'b1;
    wrReg(`SPS_ADDR_CTRL, 32'h90);
    repeat (3) @(posedge clk);
    #1 chk("early loop", highResp, 32'h0);
    chk("early torque", torqueLimit, 32'd300);
    apply(`SPS_ADDR_CTRL, 32'h90);
    chk("high resp", highResp, 32'h1);
    chk("ext torque", torqueLimit, 32'd350);
    motorExtOk <= 1'b0;
    @(posedge clk);
    #1 chk("ext alarm", paramError, 32'h1);
    apply(`SPS_ADDR_CTRL, 32'h0);
    chk("alarm gone", paramError, 32'h0);
    $display("test apply done");
  endtask
  task automatic tRegen;
    for (int i = 0; i < 6; i++)
    begin
      apply(`SPS_ADDR_REGEN, 32'h80 + i);
      chk("regen ok", paramError, 32'h0);
    end
    apply(`SPS_ADDR_REGEN, 32'h86);
    chk("regen bad", paramError, 32'h1);
    rdReg(`SPS_ADDR_STAT, d);
    chk("param status", d[0], 1'b1);
    apply(`SPS_ADDR_REGEN, 32'hfa);
    chk("fan refused", paramError, 32'h1);
    fanAllowed <= 1'b1;
    largeUnit <= 1'b1;
    @(posedge clk);
    #1 chk("large unit", paramError, 32'h1);
    apply(`SPS_ADDR_REGEN, 32'h0);
    chk("large fixed", paramError, 32'h0);
    largeUnit <= 1'b0;
    apply(`SPS_ADDR_REGEN, 32'hfa);
    chk("fan ok", paramError, 32'h0);
    $display("test regen done");
  endtask
  task automatic tAbs;
    for (int i = 0; i < 3; i++)
    begin
      apply(`SPS_ADDR_ABS, i);
      chk("abs mode", absMode, i);
      chk("abs active", absActive, i != 0);
    end
    apply(`SPS_ADDR_ABS, 32'h3);
    chk("abs code 3", paramError, 32'h1);
    chk("abs code 3 mode", absMode, 32'h0);
    apply(`SPS_ADDR_ABS, 32'h2);
    apply(`SPS_ADDR_CTRL, 32'h1);
    chk("abs speed", absActive, 32'h0);
    apply(`SPS_ADDR_CTRL, 32'h0);
    $display("test abs done");
  endtask
  task automatic tPinIrq;
    outputAssignDev <= 1'b1;
    apply(`SPS_ADDR_PINF, 32'h0);
    chk("pin assign", pinOut_reg, 32'h1);
    apply(`SPS_ADDR_PINF, 32'h1);
    chk("pin brake", pinOut_reg, 32'h0);
    wrReg(`SPS_ADDR_MASK, 32'hf);
    rdReg(`SPS_ADDR_STAT, d);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        wrReg(`SPS_ADDR_MASK, 32'h0);
      {overload2Ev, overload1Ev, overheatEv} <= 3'h1 << (i % 3);
      @(posedge clk);
      {overload2Ev, overload1Ev, overheatEv} <= 3'h0;
      #1 chk("irq", irq, i != 3);
      rdReg(`SPS_ADDR_STAT, d);
      chk("status", d, 32'h2 << (i % 3));
      chk("irq cleared", irq, 32'h0);
    end
    $display("test pin and irq done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {arst_n, wr, rd, servoOn, motorExtOk, largeUnit, fanAllowed} = 7'h0;
    {overheatEv, overload1Ev, overload2Ev, go, dir} = 5'h0;
    {outputAssignDev, brakeInterlock, addr, wdata, count} = 46'h0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    tReset;
    tGear;
    tApply;
    tRegen;
    tAbs;
    tPinIrq;
    tally_and_finish;
  end
endmodule
`default_nettype wire
